// ---- hdl/link_train_regs.svh ----
// register offsets, field positions and timing counts of the link training status block
`ifndef LINK_TRAIN_REGS_SVH
`define LINK_TRAIN_REGS_SVH

// ****************************************
// status channel offsets
// ****************************************
`define OFS_SRC_TEST_CONFIG 8'h35
`define OFS_TRAIN_FLAGS 8'h40
`define OFS_PATTERN_LANES_0_1 8'h41
`define OFS_PATTERN_LANES_2_3 8'h42

// ****************************************
// fields and values
// ****************************************
`define TRAIN_READY_BIT 6
`define SRC_TEST_CONFIG_MASK 8'hee
`define FIXED_PATTERN_REQ 16'h5678
`define RATE_CODE_MAX 4'h6

// ****************************************
// lock detection and timing
// ****************************************
`define LOCK_PERIOD_THREE_LANE 10'h2a8
`define LOCK_PERIOD_FOUR_LANE 10'h1fe
`define LOCK_REPEATS 2'h3
`define HPD_DELAY_MS 1000
`define REF_CLK_KHZ 50000

`endif

// ---- hdl/link_train_pkg.sv ----
// types shared by the link training status block
package link_train_pkg;

    typedef enum logic [1:0] {
        LANES_OFF,
        LANES_THREE,
        LANES_FOUR
    } lane_mode_e;

    // rate code to lane configuration
    function automatic lane_mode_e lane_mode_of(input logic [3:0] code);
        lane_mode_of = (code == 4'h1 || code == 4'h2) ? LANES_THREE :
                       (code >= 4'h3 && code <= 4'h6) ? LANES_FOUR : LANES_OFF;
    endfunction : lane_mode_of

endpackage : link_train_pkg

// ---- hdl/lane_lock_if.sv ----
// carrier between the status block and its per-lane lock detector
`timescale 1ns/1ps
interface lane_lock_if;
    logic clear;
    logic [9:0] period;
    logic [3:0] lane_en;
    logic [3:0] char_valid;
    logic [3:0] sync_seen;
    logic [3:0] locked;

    modport ctrl (output clear, output period, output lane_en, output char_valid, output sync_seen, input locked);
    modport det (input clear, input period, input lane_en, input char_valid, input sync_seen, output locked);
endinterface : lane_lock_if

// ---- hdl/lane_lock_detect.sv ----
// per-lane lock detection from repeated sync character spacing
`timescale 1ns/1ps
`include "link_train_regs.svh"
module lane_lock_detect (
    input wire logic ref_clk,
    input wire logic rst,
    lane_lock_if.det lk
);

    // ****************************************
    // one detector per lane
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            logic [9:0] cnt_q, cnt_d;
            logic [1:0] reps_q, reps_d;
            logic armed_q, armed_d;
            logic lock_q, lock_d;
            wire idle = lk.clear || !lk.lane_en[g];
            wire at_period = armed_q && (cnt_q == lk.period);
            wire good_sync = lk.char_valid[g] && lk.sync_seen[g] && at_period;
            wire bad_sync = lk.char_valid[g] && lk.sync_seen[g] && !at_period;
            wire missed = lk.char_valid[g] && !lk.sync_seen[g] && at_period;
            wire step = lk.char_valid[g] && !lk.sync_seen[g] && armed_q && !at_period;
            wire [1:0] reps_inc = (reps_q == `LOCK_REPEATS) ? reps_q : reps_q + 2'h1;

            assign cnt_d = idle || missed ? 10'h000 : (good_sync || bad_sync) ? 10'h001 : step ? cnt_q + 10'h001 : cnt_q;
            assign reps_d = idle || missed || bad_sync ? 2'h0 : good_sync ? reps_inc : reps_q; // see RULE3 see RULE5
            assign armed_d = idle || missed ? 1'b0 : (good_sync || bad_sync) ? 1'b1 : armed_q;
            assign lock_d = idle || missed || bad_sync ? 1'b0 : good_sync && reps_inc == `LOCK_REPEATS ? 1'b1 : lock_q;

            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    cnt_q <= 10'h000;
                    reps_q <= 2'h0;
                    armed_q <= 1'b0;
                    lock_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_d;
                    reps_q <= reps_d;
                    armed_q <= armed_d;
                    lock_q <= lock_d;
                end
            end

            assign lk.locked[g] = lock_q;

            property p_lock_rise;
                @(posedge ref_clk) disable iff (rst)
                $rose(lock_q) |-> $past(reps_q) == 2'h2 && $past(lk.sync_seen[g]) && $past(cnt_q) == $past(lk.period);
            endproperty
            a_lock_rise: assert property (p_lock_rise) else $error("lane lock rose without third spaced sync"); // see RULE3
        end
    endgenerate

endmodule : lane_lock_detect

// ---- hdl/sink_link_training_status.sv ----
// receiver link training control, status registers and hot-plug request
// Contract
// RULE1 - report link rate as 4-bit code
// RULE2 - one lock status bit per lane
// RULE3 - three-lane lock: sync spaced 680, thrice
// RULE4 - three-lane mode never sets lane 3 lock
// RULE5 - four-lane lock: sync spaced 510, thrice
// RULE6 - pattern nibbles mapped into 0x41, 0x42
// RULE7 - user drives zero pattern to pass training
// RULE8 - request disabled by default, fixed 0x5678
// RULE9 - user avoids 0xeeee and 0xffff patterns
// RULE10 - no autonomous link rate fallback
// RULE11 - user raises ready only when receiver ready
// RULE12 - ready sets bit6, clears start, sets update
// RULE13 - test configuration copied into 0x35
// RULE14 - system wires hot-plug output to connector
// RULE15 - hot-plug low without supply, after reset
// RULE16 - hot-plug high one second after supply
// RULE17 - lock bits cleared on rate change
`timescale 1ns/1ps
`include "link_train_regs.svh"
module sink_link_training_status #(
    parameter int unsigned HPD_DELAY_CYCLES = `HPD_DELAY_MS * `REF_CLK_KHZ
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] rate_code_in,
    input wire logic [3:0] char_valid_in,
    input wire logic [3:0] sync_char_in,
    input wire logic pattern_req_enable,
    input wire logic [15:0] pattern_req_in,
    input wire logic training_ready_in,
    input wire logic update_flag_clear,
    input wire logic [7:0] test_config_in,
    input wire logic supply_presence_in,
    input wire logic [7:0] reg_addr,
    output logic [3:0] link_rate_q,
    output logic [3:0] lane_locked_q,
    output logic training_start_q,
    output logic training_update_q,
    output logic hot_plug_req_q,
    output logic [7:0] reg_rdata_q
);

    localparam int CW = $clog2(HPD_DELAY_CYCLES + 1);
    localparam logic [CW-1:0] HPD_LAST = CW'(HPD_DELAY_CYCLES - 1);

    // ****************************************
    // link rate and lane mode
    // ****************************************
    logic [3:0] link_rate_d;
    link_train_pkg::lane_mode_e mode_d;
    logic rate_change;

    assign link_rate_d = (rate_code_in <= `RATE_CODE_MAX) ? rate_code_in : 4'h0; // see RULE1 see RULE10
    assign mode_d = link_train_pkg::lane_mode_of(link_rate_d);
    assign rate_change = link_rate_d != link_rate_q;

    // ****************************************
    // lane lock
    // ****************************************
    lane_lock_if lock_bus ();
    logic [3:0] lane_locked_d;

    assign lock_bus.clear = rate_change || mode_d == link_train_pkg::LANES_OFF; // see RULE17
    assign lock_bus.period = (mode_d == link_train_pkg::LANES_THREE) ? `LOCK_PERIOD_THREE_LANE
                                                                      : `LOCK_PERIOD_FOUR_LANE; // see RULE3 see RULE5
    assign lock_bus.lane_en = (mode_d == link_train_pkg::LANES_FOUR) ? 4'hf :
                              (mode_d == link_train_pkg::LANES_THREE) ? 4'h7 : 4'h0; // see RULE4
    assign lock_bus.char_valid = char_valid_in;
    assign lock_bus.sync_seen = sync_char_in;
    assign lane_locked_d = lock_bus.clear ? 4'h0 : lock_bus.locked & lock_bus.lane_en; // see RULE2 see RULE17

    lane_lock_detect u_detect (
        .ref_clk(ref_clk),
        .rst(rst),
        .lk(lock_bus)
    );

    // ****************************************
    // training flags, pattern and configuration
    // ****************************************
    logic [15:0] pattern_q, pattern_d;
    logic [7:0] test_cfg_q, test_cfg_d;
    logic ready_q;
    logic start_d, update_d;

    assign pattern_d = pattern_req_enable ? pattern_req_in : `FIXED_PATTERN_REQ; // see RULE8
    assign test_cfg_d = test_config_in & `SRC_TEST_CONFIG_MASK; // see RULE13
    // ready clears start over a same-cycle rate change; update set wins over clear
    assign start_d = training_ready_in ? 1'b0 : (rate_change ? 1'b1 : training_start_q); // see RULE12
    assign update_d = training_ready_in && !ready_q ? 1'b1 : (update_flag_clear ? 1'b0 : training_update_q); // see RULE12

    // ****************************************
    // hot-plug delay
    // ****************************************
    logic [CW-1:0] hpd_cnt_q, hpd_cnt_d;
    logic hpd_d;

    assign hpd_cnt_d = !supply_presence_in ? '0 : (hpd_cnt_q == HPD_LAST ? hpd_cnt_q : hpd_cnt_q + 1'b1); // see RULE16
    assign hpd_d = supply_presence_in && hpd_cnt_q == HPD_LAST; // see RULE15 see RULE16

    // ****************************************
    // status register read
    // ****************************************
    logic [7:0] rdata_d;
    logic [7:0] flags_word;

    assign flags_word = 8'(ready_q) << `TRAIN_READY_BIT; // see RULE12
    assign rdata_d = (reg_addr == `OFS_SRC_TEST_CONFIG) ? test_cfg_q :
                     (reg_addr == `OFS_TRAIN_FLAGS) ? flags_word :
                     (reg_addr == `OFS_PATTERN_LANES_0_1) ? pattern_q[7:0] :
                     (reg_addr == `OFS_PATTERN_LANES_2_3) ? pattern_q[15:8] : 8'h00; // see RULE6

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            link_rate_q <= 4'h0;
            lane_locked_q <= 4'h0;
            pattern_q <= `FIXED_PATTERN_REQ;
            test_cfg_q <= 8'h00;
            ready_q <= 1'b0;
            training_start_q <= 1'b0;
            training_update_q <= 1'b0;
            hpd_cnt_q <= '0;
            hot_plug_req_q <= 1'b0;
            reg_rdata_q <= 8'h00;
        end else begin
            link_rate_q <= link_rate_d;
            lane_locked_q <= lane_locked_d;
            pattern_q <= pattern_d;
            test_cfg_q <= test_cfg_d;
            ready_q <= training_ready_in;
            training_start_q <= start_d;
            training_update_q <= update_d;
            hpd_cnt_q <= hpd_cnt_d;
            hot_plug_req_q <= hpd_d;
            reg_rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_ready_rise;
        !training_ready_in ##1 training_ready_in;
    endsequence

    property p_rate_follow;
        @(posedge ref_clk) disable iff (rst)
        rate_code_in <= 4'h6 |=> link_rate_q == $past(rate_code_in);
    endproperty
    a_rate_follow: assert property (p_rate_follow) else $error("link rate does not follow request"); // see RULE1

    property p_lane3_off;
        @(posedge ref_clk) disable iff (rst)
        (link_rate_q == 4'h1 || link_rate_q == 4'h2) |-> !lane_locked_q[3];
    endproperty
    a_lane3_off: assert property (p_lane3_off) else $error("lane 3 locked in three-lane mode"); // see RULE4

    property p_rate_clear;
        @(posedge ref_clk) disable iff (rst)
        ($changed(link_rate_q) || link_rate_q == 4'h0) |-> lane_locked_q == 4'h0;
    endproperty
    a_rate_clear: assert property (p_rate_clear) else $error("lock kept across rate change"); // see RULE17

    property p_period;
        @(posedge ref_clk) disable iff (rst)
        link_rate_d >= 4'h3 |-> lock_bus.period == 10'h1fe;
    endproperty
    a_period: assert property (p_period) else $error("wrong four-lane lock spacing"); // see RULE5

    property p_pattern;
        @(posedge ref_clk) disable iff (rst)
        !pattern_req_enable |=> pattern_q == 16'h5678;
    endproperty
    a_pattern: assert property (p_pattern) else $error("fixed pattern not requested"); // see RULE8

    property p_lane_map;
        @(posedge ref_clk) disable iff (rst)
        reg_addr == 8'h42 |=> reg_rdata_q == $past(pattern_q[15:8]);
    endproperty
    a_lane_map: assert property (p_lane_map) else $error("lanes 2 and 3 pattern misplaced"); // see RULE6

    property p_ready;
        @(posedge ref_clk) disable iff (rst)
        s_ready_rise |=> ready_q && training_update_q && !training_start_q ##0 flags_word[6];
    endproperty
    a_ready: assert property (p_ready) else $error("ready did not update training flags"); // see RULE12

    property p_test_cfg;
        @(posedge ref_clk) disable iff (rst)
        reg_addr == 8'h35 ##1 reg_addr == 8'h35 |=> reg_rdata_q == ($past(test_config_in, 2) & 8'hee);
    endproperty
    a_test_cfg: assert property (p_test_cfg) else $error("test configuration not reflected"); // see RULE13

    property p_hpd_low;
        @(posedge ref_clk) disable iff (rst)
        !supply_presence_in |=> !hot_plug_req_q;
    endproperty
    a_hpd_low: assert property (p_hpd_low) else $error("hot-plug raised without supply"); // see RULE15

    property p_hpd_rise;
        @(posedge ref_clk) disable iff (rst)
        $rose(hot_plug_req_q) |-> $past(hpd_cnt_q) == HPD_LAST && $past(supply_presence_in);
    endproperty
    a_hpd_rise: assert property (p_hpd_rise) else $error("hot-plug raised before delay"); // see RULE16

    property p_hpd_hold;
        @(posedge ref_clk) disable iff (rst)
        hot_plug_req_q && supply_presence_in |=> hot_plug_req_q;
    endproperty
    a_hpd_hold: assert property (p_hpd_hold) else $error("hot-plug dropped while supply present"); // see RULE16

    property p_rate_invalid;
        @(posedge ref_clk) disable iff (rst)
        rate_code_in > 4'h6 |=> link_rate_q == 4'h0;
    endproperty
    a_rate_invalid: assert property (p_rate_invalid) else $error("unknown rate code not reported as off"); // see RULE1

    property p_start_clear;
        @(posedge ref_clk) disable iff (rst)
        training_ready_in |=> !training_start_q;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start flag kept while ready"); // see RULE12

    property p_lane_map_low;
        @(posedge ref_clk) disable iff (rst)
        reg_addr == 8'h41 |=> reg_rdata_q == $past(pattern_q[7:0]);
    endproperty
    a_lane_map_low: assert property (p_lane_map_low) else $error("lanes 0 and 1 pattern misplaced"); // see RULE6

endmodule : sink_link_training_status

// ---- sim/status_reader.sv ----
// source-side model that reads the status registers
`timescale 1ns/1ps
module status_reader (
    input wire logic ref_clk,
    input wire logic [7:0] reg_rdata_q,
    output logic [7:0] reg_addr
);
    // ****
    // register read
    // ****
    initial begin
        reg_addr = 8'h00;
    end
    // address held through the taking edge, data taken once settled
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        @(posedge ref_clk);
        @(negedge ref_clk);
        d = reg_rdata_q;
    endtask : read
endmodule : status_reader

// ---- sim/sink_link_training_status_test.sv ----
// self-checking bench of the link training status block
`timescale 1ns/1ps
module sink_link_training_status_test;
    // ****
    // bench and scenarios
    // ****
    localparam int unsigned HPD = 20;
    logic ref_clk, rst, pattern_req_enable, training_ready_in, update_flag_clear, supply_presence_in;
    logic [3:0] rate_code_in, char_valid_in, sync_char_in, link_rate_q, lane_locked_q;
    logic [15:0] pattern_req_in;
    logic [7:0] test_config_in, reg_addr, reg_rdata_q, rd;
    logic training_start_q, training_update_q, hot_plug_req_q;
    int err_total, tests_run;
    sink_link_training_status #(.HPD_DELAY_CYCLES(HPD)) dut (
        .ref_clk(ref_clk), .rst(rst), .rate_code_in(rate_code_in), .char_valid_in(char_valid_in),
        .sync_char_in(sync_char_in), .pattern_req_enable(pattern_req_enable), .pattern_req_in(pattern_req_in),
        .training_ready_in(training_ready_in), .update_flag_clear(update_flag_clear),
        .test_config_in(test_config_in), .supply_presence_in(supply_presence_in), .reg_addr(reg_addr),
        .link_rate_q(link_rate_q), .lane_locked_q(lane_locked_q), .training_start_q(training_start_q),
        .training_update_q(training_update_q), .hot_plug_req_q(hot_plug_req_q), .reg_rdata_q(reg_rdata_q)
    );
    status_reader src (.ref_clk(ref_clk), .reg_rdata_q(reg_rdata_q), .reg_addr(reg_addr));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    task automatic cmp_val(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_val
    task automatic cmp_flag(input string n, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %b seen %b", n, e, g);
        end
    endtask : cmp_flag
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    task automatic check_reg(input logic [7:0] a, input logic [7:0] e);
        src.read(a, rd);
        cmp_val("status register", e, rd);
    endtask : check_reg
    task automatic pattern_test;
        check_reg(8'h41, 8'h78);
        check_reg(8'h42, 8'h56);
        @(posedge ref_clk);
        pattern_req_enable <= 1'b1;
        pattern_req_in <= 16'h1234;
        tick(2);
        check_reg(8'h41, 8'h34);
        check_reg(8'h42, 8'h12);
        @(posedge ref_clk);
        pattern_req_in <= 16'h0000;
        tick(2);
        check_reg(8'h42, 8'h00);
        check_reg(8'h99, 8'h00);
    endtask : pattern_test
    task automatic config_test;
        @(posedge ref_clk);
        test_config_in <= 8'hff;
        tick(2);
        check_reg(8'h35, 8'hee);
        @(posedge ref_clk);
        test_config_in <= 8'ha5;
        tick(2);
        check_reg(8'h35, 8'ha4);
    endtask : config_test
    task automatic rate_test;
        for (int c = 0; c < 9; c++) begin
            @(posedge ref_clk);
            rate_code_in <= c[3:0];
            tick(2);
            @(negedge ref_clk);
            cmp_val("link rate", (c <= 6) ? c[7:0] : 8'h00, {4'h0, link_rate_q});
        end
        cmp_flag("training start", 1'b1, training_start_q);
    endtask : rate_test
    task automatic lock_run(input logic [3:0] code, input int p, input logic [3:0] mask);
        @(posedge ref_clk);
        rate_code_in <= code;
        tick(3);
        for (int i = 0; i <= 3 * p; i++) begin
            @(posedge ref_clk);
            char_valid_in <= 4'hf;
            sync_char_in <= (i % p == 0) ? 4'hf : 4'h0;
            if (i == 3 * p) begin
                @(negedge ref_clk);
                cmp_val("early lock", 8'h00, {4'h0, lane_locked_q});
            end
        end
        @(posedge ref_clk);
        sync_char_in <= 4'h0;
        tick(2);
        @(negedge ref_clk);
        cmp_val("lock", {4'h0, mask}, {4'h0, lane_locked_q});
        cmp_val("link rate", {4'h0, code}, {4'h0, link_rate_q});
    endtask : lock_run
    task automatic lock_clear(input logic [3:0] code);
        @(posedge ref_clk);
        rate_code_in <= code;
        tick(2);
        @(negedge ref_clk);
        cmp_val("lock after rate change", 8'h00, {4'h0, lane_locked_q});
    endtask : lock_clear
    task automatic lock_test;
        lock_run(4'h1, 680, 4'h7);
        lock_clear(4'h2);
        lock_run(4'h3, 510, 4'hf);
        lock_clear(4'h0);
    endtask : lock_test
    task automatic flags_test;
        @(posedge ref_clk);
        training_ready_in <= 1'b1;
        tick(2);
        @(negedge ref_clk);
        cmp_flag("training update", 1'b1, training_update_q);
        cmp_flag("training start", 1'b0, training_start_q);
        check_reg(8'h40, 8'h40);
        @(posedge ref_clk);
        update_flag_clear <= 1'b1;
        @(posedge ref_clk);
        update_flag_clear <= 1'b0;
        tick(1);
        @(negedge ref_clk);
        cmp_flag("training update", 1'b0, training_update_q);
    endtask : flags_test
    task automatic hpd_test;
        cmp_flag("hot plug", 1'b0, hot_plug_req_q);
        @(posedge ref_clk);
        supply_presence_in <= 1'b1;
        tick(HPD - 1);
        @(negedge ref_clk);
        cmp_flag("hot plug", 1'b0, hot_plug_req_q);
        tick(1);
        @(negedge ref_clk);
        cmp_flag("hot plug", 1'b1, hot_plug_req_q);
        @(posedge ref_clk);
        supply_presence_in <= 1'b0;
        tick(2);
        @(negedge ref_clk);
        cmp_flag("hot plug", 1'b0, hot_plug_req_q);
    endtask : hpd_test
    initial begin
        err_total = 0;
        tests_run = 0;
        rst = 1'b1;
        rate_code_in = 4'h0;
        char_valid_in = 4'h0;
        sync_char_in = 4'h0;
        pattern_req_enable = 1'b0;
        pattern_req_in = 16'h0000;
        training_ready_in = 1'b0;
        update_flag_clear = 1'b0;
        test_config_in = 8'h00;
        supply_presence_in = 1'b0;
        tick(16);
        rst <= 1'b0;
        tick(2);
        pattern_test;
        config_test;
        rate_test;
        lock_test;
        flags_test;
        hpd_test;
        stop_test;
    end
    initial begin
        #400000;
        err_total++;
        stop_test;
    end
endmodule : sink_link_training_status_test
